// ### hw/spi_cmd_pkg.sv
// Constants, types and carriers shared by the SPI command frame slave
package spi_cmd_pkg;

   // Frame geometry
   localparam int WORD_W   = 16;
   localparam int CNT_W    = 4;
   localparam int DIAG_W   = 15;
   localparam int DATA10_W = 10;
   localparam int DATA8_W  = 8;

   // Field positions inside a 16-bit frame
   localparam int OP_HI   = 15;
   localparam int OP_LO   = 14;
   localparam int PRI_HI  = 13;
   localparam int PRI_LO  = 10;
   localparam int SEC_HI  = 9;
   localparam int SEC_LO  = 8;
   localparam int TAIL_HI = 1;
   localparam int TAIL_LO = 0;
   localparam int TER_BIT = 10;

   // Command codes
   localparam logic [1:0] OP_WRITE     = 2'h2;
   localparam logic [1:0] OP_READ      = 2'h1;
   localparam logic [1:0] TAIL_DIAG    = 2'h1;
   localparam logic [1:0] TAIL_READ    = 2'h2;
   localparam logic [1:0] ANS_REG_HEAD = 2'h2;

   // Bit counting: a good frame is 16 clocks plus a multiple of 8
   localparam logic [CNT_W-1:0] CNT_ONE   = 4'h1;
   localparam logic [CNT_W-1:0] CNT_LAST  = 4'hf;
   localparam logic [2:0]       MOD8_ZERO = 3'h0;

   // Implemented registers: one bit per primary address for 10-bit
   // registers, one bit per {primary, secondary} pair for 8-bit ones
   localparam logic [15:0] TEN_BIT_MAP   = 16'h0300;
   localparam logic [63:0] EIGHT_BIT_MAP = 64'h0000_0000_ffff_ffff;

   // Reset values
   localparam logic [WORD_W-1:0]   ANSWER_RST = 16'h0400;
   localparam logic [DATA10_W-1:0] DATA_RST   = 10'h000;

   typedef enum logic [2:0] {
      ANS_DIAG = 3'b001,
      ANS_ERR  = 3'b010,
      ANS_REG  = 3'b100
   } answer_e;

   typedef enum logic [1:0] {
      ST_IDLE  = 2'b01,
      ST_FETCH = 2'b10
   } ctl_state_e;

   typedef struct packed {
      logic [3:0] primary_reg_address;
      logic [1:0] secondary_reg_address;
      logic       tenBit;
   } reg_addr_s;

   typedef struct packed {
      logic                strobe;
      reg_addr_s           addr;
      logic [DATA10_W-1:0] data;
   } reg_write_s;

   typedef struct packed {
      logic [WORD_W-1:0] word;
      logic [CNT_W-1:0]  count;
      logic              past16;
   } link_rx_s;

endpackage

// ### hw/spi_command_frame.sv
// SPI command frame slave: serial link, frame decode and answer builder
`timescale 1ns/100ps
`default_nettype none

// How it works
// - The answer to a frame is sent during the following frame.
// - A frame under 16 clocks or not a multiple of 8 is a transfer error.
// - After reset or software reset the first answer is a special one.
// - Bad write or read opcodes and unused addresses are syntax errors.
// - 0...01 reads the standard diagnosis: zero then fifteen diag bits.
// - 10 plus a 10-bit register address writes its ten low data bits.
// - 01 addr .. 10 on a 10-bit register answers 10, address, content.
// - 10 addr sub data writes an 8-bit register, answer is diagnosis.
// - 01 addr sub .. 10 reads an 8-bit register: 10, addresses, content.
// - The data output is undriven while chip select is high.
// - The data output is driven from the fall of chip select onward.
// - Bit 10 of the diagnosis word is the transfer error flag.
// - After reset the flag reads set once, then clears if all is well.
// - Each clock shifts data in and the displaced bit out, for chaining.
// - The frame is acted on only when chip select rises after it.
module spi_command_frame (
   input  wire logic                           ref_clk,
   input  wire logic                           reset,
   input  wire logic                           sclk,
   input  wire logic                           csnN,
   input  wire logic                           si,
   output logic                                so,
   output logic                                soOe,
   input  wire logic [spi_cmd_pkg::DIAG_W-1:0] diagStatus,
   input  wire logic                           swReset,
   input  wire logic [spi_cmd_pkg::DATA10_W-1:0] regRdData,
   output spi_cmd_pkg::reg_write_s             regWr,
   output spi_cmd_pkg::reg_addr_s              regRdAddr
);

   typedef struct packed {
      logic                          csnPrev;
      logic                          togSeen;
      spi_cmd_pkg::ctl_state_e       state;
      spi_cmd_pkg::answer_e          kind;
      logic [spi_cmd_pkg::WORD_W-1:0] regWord;
      logic [spi_cmd_pkg::WORD_W-1:0] answer;
      spi_cmd_pkg::reg_addr_s        rdAddr;
      spi_cmd_pkg::reg_write_s       wr;
   } ctl_s;

   // Link side state, one struct per clock edge in use
   typedef struct packed {
      logic soBit;
      logic start;
   } link_tx_s;

   ctl_s                  ctl_q;
   ctl_s                  ctl_d;
   spi_cmd_pkg::link_rx_s rx_q;
   spi_cmd_pkg::link_rx_s rx_d;
   link_tx_s              tx_q;
   link_tx_s              tx_d;
   logic                  fresh_q;
   logic                  frameTog_q;
   logic                  linkIdle;
   logic                  csnSync;
   logic                  frameDone;
   logic                  frameOk;
   logic [1:0]            opCode;
   logic [1:0]            tailCode;
   logic [3:0]            priAddr;
   logic [1:0]            secAddr;
   logic                  isTen;
   logic                  isEight;
   logic                  isDiagRead;
   logic [spi_cmd_pkg::WORD_W-1:0] rxWord;
   logic [spi_cmd_pkg::WORD_W-1:0] diagWord;

   // ------------------------------------------------------------------
   // Link domain, clocked by the serial clock. Chip select high holds the
   // frame-start flags set, so they need no serial clock edge to arm.
   // ------------------------------------------------------------------
   assign linkIdle = reset | csnN;

   always_ff @(negedge sclk or posedge linkIdle) begin
      if (linkIdle) begin
         fresh_q <= 1'b1;
      end else begin
         fresh_q <= 1'b0;
      end
   end

   // Flips on the first falling edge of each frame: a frame with no clock at all
   // must not replay the word left over from the one before
   always_ff @(negedge sclk or posedge reset) begin
      if (reset) begin
         frameTog_q <= 1'b0;
      end else if (fresh_q) begin
         frameTog_q <= ~frameTog_q;
      end
   end

   always_comb begin
      rx_d = rx_q;
      if (fresh_q) begin
         // First falling edge: load the pending answer behind its MSB
         rx_d.word   = {ctl_q.answer[spi_cmd_pkg::WORD_W-2:0], si};
         rx_d.count  = spi_cmd_pkg::CNT_ONE;
         rx_d.past16 = 1'b0;
      end else begin
         rx_d.word   = {rx_q.word[spi_cmd_pkg::WORD_W-2:0], si};
         rx_d.count  = rx_q.count + spi_cmd_pkg::CNT_ONE;
         rx_d.past16 = rx_q.past16 |
                       (rx_q.count == spi_cmd_pkg::CNT_LAST);
      end
   end

   always_ff @(negedge sclk or posedge reset) begin
      if (reset) begin
         rx_q <= '0;
      end else begin
         rx_q <= rx_d;
      end
   end

   always_comb begin
      tx_d.start = 1'b0;
      tx_d.soBit = tx_q.start ? ctl_q.answer[spi_cmd_pkg::OP_HI]
                              : rx_q.word[spi_cmd_pkg::WORD_W-1];
   end

   always_ff @(posedge sclk or posedge linkIdle) begin
      if (linkIdle) begin
         tx_q <= '{soBit: 1'b0, start: 1'b1};
      end else begin
         tx_q <= tx_d;
      end
   end

   // Before the first rising edge the answer MSB goes straight out, so the
   // pin is valid as soon as chip select falls
   assign so   = tx_q.start ? ctl_q.answer[spi_cmd_pkg::OP_HI]
                            : tx_q.soBit;
   assign soOe = ~csnN;

   // ------------------------------------------------------------------
   // Reference clock domain. The received word and count are read only
   // after synchronised chip select rises, when the serial clock is still,
   // and the answer only moves while chip select is high: both words are
   // quasi-static at the crossing, qualified by the synchronised select.
   // ------------------------------------------------------------------
   sync_two_ff #(
      .WIDTH     (1),
      .RESET_VAL (1'b1)
   ) u_csn_sync (
      .ref_clk  (ref_clk),
      .reset    (reset),
      .async_in (csnN),
      .sync_out (csnSync)
   );

   assign frameDone = csnSync & ~ctl_q.csnPrev;
   assign frameOk   = rx_q.past16 &&
                      (rx_q.count[2:0] == spi_cmd_pkg::MOD8_ZERO) &&
                      (frameTog_q != ctl_q.togSeen);

   assign rxWord   = rx_q.word;
   assign opCode   = rxWord[spi_cmd_pkg::OP_HI:spi_cmd_pkg::OP_LO];
   assign tailCode = rxWord[spi_cmd_pkg::TAIL_HI:spi_cmd_pkg::TAIL_LO];
   assign priAddr  = rxWord[spi_cmd_pkg::PRI_HI:spi_cmd_pkg::PRI_LO];
   assign secAddr  = rxWord[spi_cmd_pkg::SEC_HI:spi_cmd_pkg::SEC_LO];
   // Width is picked by the primary address alone
   assign isTen    = spi_cmd_pkg::TEN_BIT_MAP[priAddr];
   assign isEight  = !isTen &&
                     spi_cmd_pkg::EIGHT_BIT_MAP[{priAddr, secAddr}];
   assign isDiagRead = !rxWord[spi_cmd_pkg::OP_HI] &&
                       (tailCode == spi_cmd_pkg::TAIL_DIAG);

   // Diagnosis bits are live; bit 10 is replaced by the error flag
   assign diagWord = {1'b0,
                      diagStatus[spi_cmd_pkg::DIAG_W-1:spi_cmd_pkg::TER_BIT+1],
                      ctl_q.kind != spi_cmd_pkg::ANS_DIAG,
                      diagStatus[spi_cmd_pkg::TER_BIT-1:0]};

   always_comb begin
      ctl_d           = ctl_q;
      ctl_d.csnPrev   = csnSync;
      ctl_d.wr.strobe = 1'b0;
      if (frameDone) begin
         ctl_d.togSeen = frameTog_q;
      end
      unique case (ctl_q.state)
         spi_cmd_pkg::ST_IDLE: begin
            if (frameDone) begin
               if (!frameOk) begin
                  ctl_d.kind = spi_cmd_pkg::ANS_ERR;
               end else if (isDiagRead) begin
                  ctl_d.kind = spi_cmd_pkg::ANS_DIAG;
               end else if (opCode == spi_cmd_pkg::OP_WRITE &&
                            (isTen || isEight)) begin
                  ctl_d.wr.strobe = 1'b1;
                  ctl_d.wr.addr   = '{primary_reg_address: priAddr,
                                      secondary_reg_address: secAddr,
                                      tenBit: isTen};
                  ctl_d.wr.data   = isTen ?
                     rxWord[spi_cmd_pkg::DATA10_W-1:0] :
                     {2'b00, rxWord[spi_cmd_pkg::DATA8_W-1:0]};
                  ctl_d.kind      = spi_cmd_pkg::ANS_DIAG;
               end else if (opCode == spi_cmd_pkg::OP_READ &&
                            tailCode == spi_cmd_pkg::TAIL_READ &&
                            (isTen || isEight)) begin
                  ctl_d.rdAddr = '{primary_reg_address: priAddr,
                                   secondary_reg_address: secAddr,
                                   tenBit: isTen};
                  ctl_d.state  = spi_cmd_pkg::ST_FETCH;
               end else begin
                  // Opcode 11 or 00, a read without tail 10, or nothing at that address
                  ctl_d.kind = spi_cmd_pkg::ANS_ERR;
               end
            end
         end
         spi_cmd_pkg::ST_FETCH: begin
            // Register file answers combinationally to the address flops
            ctl_d.kind  = spi_cmd_pkg::ANS_REG;
            ctl_d.state = spi_cmd_pkg::ST_IDLE;
            if (ctl_q.rdAddr.tenBit) begin
               ctl_d.regWord = {spi_cmd_pkg::ANS_REG_HEAD,
                                ctl_q.rdAddr.primary_reg_address,
                                regRdData};
            end else begin
               ctl_d.regWord = {spi_cmd_pkg::ANS_REG_HEAD,
                                ctl_q.rdAddr.primary_reg_address,
                                ctl_q.rdAddr.secondary_reg_address,
                                regRdData[spi_cmd_pkg::DATA8_W-1:0]};
            end
         end
         default: begin
            ctl_d.state = spi_cmd_pkg::ST_IDLE;
         end
      endcase
      if (swReset) begin
         ctl_d.kind  = spi_cmd_pkg::ANS_ERR;
         ctl_d.state = spi_cmd_pkg::ST_IDLE;
      end
      // Freeze the answer once a frame may be under way
      if (csnSync) begin
         ctl_d.answer = (ctl_q.kind == spi_cmd_pkg::ANS_REG) ?
                        ctl_q.regWord : diagWord;
      end
   end

   always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         ctl_q.csnPrev <= 1'b1;
         ctl_q.togSeen <= 1'b0;
         ctl_q.state   <= spi_cmd_pkg::ST_IDLE;
         ctl_q.kind    <= spi_cmd_pkg::ANS_ERR;
         ctl_q.regWord <= spi_cmd_pkg::ANSWER_RST;
         ctl_q.answer  <= spi_cmd_pkg::ANSWER_RST;
         ctl_q.rdAddr  <= '0;
         ctl_q.wr      <= '0;
      end else begin
         ctl_q <= ctl_d;
      end
   end

   assign regWr     = ctl_q.wr;
   assign regRdAddr = ctl_q.rdAddr;

   // ------------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------------
   chk_drive_in_frame: assert property (
      @(negedge sclk) disable iff (reset)
      !csnN |-> soOe &&
                (!fresh_q || so == ctl_q.answer[spi_cmd_pkg::OP_HI]))
      else $error("data output not driven during a frame");

   chk_shift_through: assert property (
      @(negedge sclk) disable iff (linkIdle)
      !fresh_q |=> rx_q.word[0] == $past(si) &&
                   rx_q.word[spi_cmd_pkg::WORD_W-1:1] ==
                   $past(rx_q.word[spi_cmd_pkg::WORD_W-2:0]))
      else $error("received bit not shifted in");

   chk_bad_count: assert property (
      @(posedge ref_clk) disable iff (reset)
      frameDone && !frameOk && !swReset
      |-> ##2 ctl_q.answer[spi_cmd_pkg::TER_BIT] &&
              !ctl_q.answer[spi_cmd_pkg::OP_HI])
      else $error("transfer error not reported");

   chk_sw_reset: assert property (
      @(posedge ref_clk) disable iff (reset)
      swReset ##1 (!swReset && csnSync)[*2]
      |-> ctl_q.answer[spi_cmd_pkg::TER_BIT])
      else $error("special answer missing after software reset");

   chk_diag_answer: assert property (
      @(posedge ref_clk) disable iff (reset)
      frameDone && frameOk && isDiagRead && !swReset ##1 csnSync[*2]
      |-> !ctl_q.answer[spi_cmd_pkg::OP_HI] &&
          !ctl_q.answer[spi_cmd_pkg::TER_BIT])
      else $error("diagnosis answer wrong");

   chk_write_strobe: assert property (
      @(posedge ref_clk) disable iff (reset)
      frameDone && frameOk && !isDiagRead && !swReset &&
      opCode == spi_cmd_pkg::OP_WRITE && isTen
      |=> regWr.strobe && regWr.addr.tenBit &&
          regWr.data == $past(rxWord[spi_cmd_pkg::DATA10_W-1:0]))
      else $error("10-bit write not issued");

   chk_syntax_error: assert property (
      @(posedge ref_clk) disable iff (reset)
      frameDone && frameOk && opCode == 2'h3
      |=> !regWr.strobe ##1 (!csnSync ||
                             ctl_q.answer[spi_cmd_pkg::TER_BIT]))
      else $error("syntax error not flagged");

   chk_read_answer: assert property (
      @(posedge ref_clk) disable iff (reset)
      frameDone && frameOk && !isDiagRead && !swReset && isTen &&
      opCode == spi_cmd_pkg::OP_READ &&
      tailCode == spi_cmd_pkg::TAIL_READ ##1 (!swReset && csnSync)[*3]
      |-> ctl_q.answer[spi_cmd_pkg::OP_HI:spi_cmd_pkg::OP_LO] ==
             spi_cmd_pkg::ANS_REG_HEAD &&
          ctl_q.answer[spi_cmd_pkg::PRI_HI:spi_cmd_pkg::PRI_LO] ==
             $past(priAddr, 3))
      else $error("register read answer wrong");

   chk_eight_write: assert property (
      @(posedge ref_clk) disable iff (reset)
      frameDone && frameOk && !isDiagRead && !swReset &&
      opCode == spi_cmd_pkg::OP_WRITE && isEight
      |=> regWr.strobe && !regWr.addr.tenBit &&
          regWr.addr.secondary_reg_address == $past(secAddr) &&
          regWr.data == {2'b00, $past(rxWord[spi_cmd_pkg::DATA8_W-1:0])})
      else $error("8-bit write not issued");

   chk_eight_read: assert property (
      @(posedge ref_clk) disable iff (reset)
      frameDone && frameOk && !isDiagRead && !swReset && isEight &&
      opCode == spi_cmd_pkg::OP_READ &&
      tailCode == spi_cmd_pkg::TAIL_READ ##1 (!swReset && csnSync)[*3]
      |-> ctl_q.answer[spi_cmd_pkg::OP_HI:spi_cmd_pkg::OP_LO] ==
             spi_cmd_pkg::ANS_REG_HEAD &&
          ctl_q.answer[spi_cmd_pkg::SEC_HI:spi_cmd_pkg::SEC_LO] ==
             $past(secAddr, 3) &&
          ctl_q.answer[spi_cmd_pkg::DATA8_W-1:0] ==
             $past(regRdData[spi_cmd_pkg::DATA8_W-1:0], 2))
      else $error("8-bit register read answer wrong");

   chk_answer_frozen: assert property (
      @(posedge ref_clk) disable iff (reset)
      !csnSync |=> $stable(ctl_q.answer))
      else $error("answer changed during a frame");

endmodule // spi_command_frame

`default_nettype wire

// ### hw/sync_two_ff.sv
// Two-flop synchroniser for levels entering the reference clock domain
`timescale 1ns/100ps
`default_nettype none

module sync_two_ff #(
   parameter int               WIDTH     = 1,
   parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
   input  wire logic             ref_clk,
   input  wire logic             reset,
   input  wire logic [WIDTH-1:0] async_in,
   output logic      [WIDTH-1:0] sync_out
);

   logic [WIDTH-1:0] meta_q;

   always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         meta_q   <= RESET_VAL;
         sync_out <= RESET_VAL;
      end else begin
         meta_q   <= async_in;
         sync_out <= meta_q;
      end
   end

endmodule // sync_two_ff

`default_nettype wire

// ### testbench/spi_host_model.sv
// Host-side SPI master model that clocks frames of 0 to 32 bits
`timescale 1ns/100ps
`default_nettype none

module spi_host_model (
   output logic      sclk,
   output logic      csnN,
   output logic      si,
   input  wire logic soLine
);
   initial begin
      sclk = 1'b0;
      csnN = 1'b1;
      si   = 1'b0;
   end

   // Sends val[n-1:0] MSB first; got collects every bit seen on the data
   // output, oldest bit highest; early is the level before the first clock
   task automatic xfer(input logic [31:0] val, input int n,
                       output logic [31:0] got, output logic early);
      got = '0;
      #3 csnN = 1'b0;
      #20 early = soLine;
      #180;
      for (int i = n - 1; i >= 0; i--) begin
         #20 si = val[i];
         #20 sclk = 1'b1;
         #38 got = {got[30:0], soLine};
         #2 sclk = 1'b0;
      end
      // Hold time over: show the opposite level, never a stale one
      #20 si = ~si;
      #180 csnN = 1'b1;
   endtask
endmodule // spi_host_model

`default_nettype wire

// ### testbench/test_spi_command_frame.sv
// Self-checking bench for the SPI command frame slave
`timescale 1ns/100ps
`default_nettype none

module test_spi_command_frame;
   logic                             ref_clk = 1'b0;
   logic                             reset = 1'b1;
   logic                             swReset = 1'b0;
   logic [spi_cmd_pkg::DIAG_W-1:0]   diagStatus = '0;
   logic [spi_cmd_pkg::DATA10_W-1:0] regRdData;
   wire logic                        sclk;
   wire logic                        csnN;
   wire logic                        si;
   wire logic                        so;
   wire logic                        soOe;
   wire logic                        soLine;
   spi_cmd_pkg::reg_write_s          regWr;
   spi_cmd_pkg::reg_addr_s           regRdAddr;
   logic [9:0]                       regFile [64];
   logic [9:0]                       shadow [64];
   logic [31:0]                      rnd = 32'he9b6;
   logic [1:0]                       expKind;
   logic [15:0]                      expWord;
   logic                             wrote;
   logic [4:0]                       wrAddr;
   int                               error_cnt = 0;
   int                               checked = 0;

   assign soLine = soOe ? so : 1'bz;
   always #4 ref_clk = ~ref_clk;

   spi_command_frame DUT (.ref_clk(ref_clk), .reset(reset), .sclk(sclk),
      .csnN(csnN), .si(si), .so(so), .soOe(soOe), .diagStatus(diagStatus),
      .swReset(swReset), .regRdData(regRdData), .regWr(regWr),
      .regRdAddr(regRdAddr));
   spi_host_model host (.sclk(sclk), .csnN(csnN), .si(si), .soLine(soLine));

   function automatic logic [5:0] key(input spi_cmd_pkg::reg_addr_s a);
      return a.tenBit ? {a.primary_reg_address, 2'b00}
                      : {a.primary_reg_address, a.secondary_reg_address};
   endfunction

   // Register file behind the block, written only by its strobes
   always @(posedge ref_clk)
      if (regWr.strobe)
         regFile[key(regWr.addr)] <= regWr.data;
   always_comb regRdData = regFile[key(regRdAddr)];

   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction

   task automatic check(input string what, input logic [31:0] seen,
                        input logic [31:0] exp);
      checked++;
      if (seen !== exp) begin
         error_cnt++;
         $display("unexpected %s: expected %h, seen %h", what, exp, seen);
      end
   endtask

   task automatic report_and_stop;
      $display("checks %0d, mismatches %0d", checked, error_cnt);
      if (error_cnt == 0 && checked > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask

   // Works out the answer that the following frame must carry
   task automatic predict(input logic [31:0] val, input int n);
      logic [15:0] c;
      logic [3:0]  p;
      logic [5:0]  k;
      logic        tb;
      c = val[15:0];
      p = c[13:10];
      tb = spi_cmd_pkg::TEN_BIT_MAP[p];
      k = tb ? {p, 2'b00} : {p, c[9:8]};
      expKind = 2'd1;
      wrote = 1'b0;
      if (n < 16 || n % 8 != 0)
         expKind = 2'd1;
      else if (!c[15] && c[1:0] == spi_cmd_pkg::TAIL_DIAG)
         expKind = 2'd0;
      else if (!(tb || spi_cmd_pkg::EIGHT_BIT_MAP[{p, c[9:8]}]))
         expKind = 2'd1;
      else if (c[15:14] == spi_cmd_pkg::OP_WRITE) begin
         expKind = 2'd0;
         shadow[k] = tb ? c[9:0] : {2'b00, c[7:0]};
         wrote = 1'b1;
         wrAddr = {p, tb};
      end else if (c[15:14] == spi_cmd_pkg::OP_READ &&
                   c[1:0] == spi_cmd_pkg::TAIL_READ) begin
         expKind = 2'd2;
         expWord = tb ? {spi_cmd_pkg::ANS_REG_HEAD, p, shadow[k]}
            : {spi_cmd_pkg::ANS_REG_HEAD, p, c[9:8], shadow[k][7:0]};
      end
   endtask

   task automatic frame(input logic [31:0] val, input int n);
      logic [31:0] got;
      logic        early;
      logic [15:0] e;
      logic [31:0] m;
      logic [4:0]  w;
      rnd = lfsr(rnd);
      @(posedge ref_clk) diagStatus <= rnd[14:0];
      repeat (10) @(posedge ref_clk);
      e = (expKind == 2'd2) ? expWord
        : {1'b0, diagStatus[14:11], expKind[0], diagStatus[9:0]};
      host.xfer(val, n, got, early);
      check("first bit", early, e[15]);
      if (n >= 16)
         check("answer", (got >> (n - 16)) & 32'hffff, e);
      else
         check("short answer", got, e >> (16 - n));
      if (n > 16) begin
         m = (32'h1 << (n - 16)) - 1;
         check("chained bits", got & m, val >> 16);
      end
      #40 check("released output", soLine, 1'bz);
      predict(val, n);
      #400;
      w = {regWr.addr.primary_reg_address, regWr.addr.tenBit};
      if (wrote)
         check("write address", w, wrAddr);
   endtask

   // Writes, reads, a diag read with a read opcode, syntax faults, then a 10-bit read
   logic [15:0] cmdTab [10] = '{16'ha2b5, 16'h6002, 16'h8e5a, 16'h4e02,
      16'h4001, 16'hc000, 16'h0002, 16'hb000, 16'h4e00, 16'h6402};
   // A select pulse with no clock at all must count as a bad frame
   int          lenTab [6] = '{0, 8, 15, 17, 24, 32};

   initial begin
      repeat (100000) @(posedge ref_clk);
      error_cnt++;
      report_and_stop();
   end

   initial begin
      logic [31:0] v;
      for (int i = 0; i < 64; i++) begin
         regFile[i] = '0;
         shadow[i] = '0;
      end
      expKind = 2'd1;
      repeat (2) @(posedge ref_clk);
      reset <= 1'b0;
      frame(32'h1, 16);
      frame(32'h1, 16);
      foreach (cmdTab[i])
         frame({16'h0, cmdTab[i]}, 16);
      foreach (lenTab[i]) begin
         rnd = lfsr(rnd);
         v = rnd & 32'((33'h1 << lenTab[i]) - 1);
         frame(v, lenTab[i]);
         frame(32'h1, 16);
      end
      @(posedge ref_clk) swReset <= 1'b1;
      @(posedge ref_clk) swReset <= 1'b0;
      expKind = 2'd1;
      frame(32'h1, 16);
      for (int i = 0; i < 40; i++) begin
         rnd = lfsr(rnd);
         v = {16'h0, rnd[15:0]};
         if (rnd[16])
            v[13:12] = 2'b00;
         if (rnd[17])
            v[1:0] = spi_cmd_pkg::TAIL_READ;
         frame(v, 16);
      end
      frame(32'h1, 16);
      report_and_stop();
   end
endmodule // test_spi_command_frame

`default_nettype wire
